// ---- rtl/tmc_compare_unit.sv ----
/*
 One output compare unit: buffered compare value, match detection and the
 output state. Assumes tick, block, load and wrap come from the counter in
 the same clock domain.
*/
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_compare_unit import tmc_pkg::*; #(
   parameter int W = 8,
   parameter bit TOGGLE_OK = 1'b0
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic tick,
   input wire logic block,
   input wire logic [W-1:0] count_value,
   input wire tmc_wave_t wave,
   input wire logic [1:0] com,
   input wire logic count_up,
   input wire logic load,
   input wire logic wrap,
   input wire logic wr,
   input wire logic [W-1:0] wdata,
   input wire logic force_cmp,
   output logic [W-1:0] active_value,
   output logic [W-1:0] read_value,
   output logic match,
   output logic out_state
);

   logic [W-1:0] buf_reg;
   logic [W-1:0] act_reg;
   logic out_reg;
   logic out_next;
   logic pwm;
   logic fast;
   logic tgl_ok;

   assign pwm = wave[0];
   assign fast = wave[0] & wave[1];
   assign tgl_ok = TOGGLE_OK && (wave == TMC_FAST_OCA || wave == TMC_PC_OCA);
   assign active_value = act_reg;
   assign read_value = pwm ? buf_reg : act_reg;
   assign out_state = out_reg;
   assign match = tick & ~block & (count_value == act_reg);

   // Buffer always takes the write
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         buf_reg <= W'(0);
      end else if (wr) begin
         buf_reg <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         act_reg <= W'(0);
      end else if (wr && !pwm) begin
         act_reg <= wdata;
      end else if (load && pwm) begin
         act_reg <= buf_reg;
      end
   end

   // Output state action; mode field used live
   always_comb begin
      out_next = out_reg;
      if (!pwm) begin
         if (match || force_cmp) begin
            case (com)
               2'b01: out_next = ~out_reg;
               2'b10: out_next = 1'b0;
               2'b11: out_next = 1'b1;
               default: out_next = out_reg;
            endcase
         end
      end else if (fast) begin
         if (match) begin
            case (com)
               2'b01: out_next = tgl_ok ? ~out_reg : out_reg;
               2'b10: out_next = 1'b0;
               2'b11: out_next = 1'b1;
               default: out_next = out_reg;
            endcase
         end
         if (wrap) begin
            case (com)
               2'b10: out_next = 1'b1;
               2'b11: out_next = 1'b0;
               default: out_next = out_next;
            endcase
         end
      end else begin
         if (match) begin
            case (com)
               2'b01: out_next = tgl_ok ? ~out_reg : out_reg;
               2'b10: out_next = ~count_up;
               2'b11: out_next = count_up;
               default: out_next = out_reg;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_com_idle;
      (com == 2'b00) |=> $stable(out_reg);
   endproperty
   a_com_idle: assert property (p_com_idle) else $error("output moved with mode zero");

   property p_force_toggle;
      (force_cmp && !pwm && com == 2'b01 && !match) |=> (out_reg != $past(out_reg));
   endproperty
   a_force_toggle: assert property (p_force_toggle) else $error("force did not toggle");

   property p_buffered;
      (pwm && wr && !load) |=> (act_reg == $past(act_reg));
   endproperty
   a_buffered: assert property (p_buffered) else $error("buffered value leaked");

   property p_direct;
      (!pwm && wr) |=> (act_reg == $past(wdata));
   endproperty
   a_direct: assert property (p_direct) else $error("direct write missed");

endmodule

// ---- rtl/tmc_timer.sv ----
/*
 8-bit timer/counter core with two compare units, reached over AHB-Lite.
 Assumes a single AHB-Lite master with single word transfers and an
 external count pin that is asynchronous to ref_clk.
*/
// How it works
// - Counter and compare values are eight bits.
// - Tick from prescaler or count pin, by select.
// - Select zero stops; counter stays accessible.
// - Each tick clears, increments or decrements per mode.
// - Software counter write beats count or clear.
// - Bottom indication when counter is zero.
// - Top is 255 or compare a, per mode.
// - Overflow flag set per mode, interrupt source.
// - Match sets compare flag on the tick.
// - Flag clears on service or written one.
// - Flags in one register, gated by mask.
// - Outputs from match, mode and output mode.
// - PWM modes buffer compare, load at top.
// - Non-PWM modes write compare directly.
// - Force strobe acts like match in non-PWM modes only, no flag.
// - Counter write blocks matches on next tick.
// - Output state survives mode changes.
// - Output mode changes act at once.
// - Normal mode counts up, overflow at wrap.
// - Clear-on-compare mode clears at compare a.
// - Fast PWM single slope, top 255 or a.
// - Output mode zero takes no action.
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_timer import tmc_pkg::*; (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic external_count_pin,
   input wire logic ack_overflow,
   input wire logic ack_compare_a,
   input wire logic ack_compare_b,
   output logic irq_overflow,
   output logic irq_compare_a,
   output logic irq_compare_b,
   output logic compare_a_output,
   output logic compare_b_output
);

   logic take;
   logic wr_pend_reg;
   logic rd_pend_reg;
   logic [7:0] addr_reg;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic wr_cta, wr_ctb, wr_ctc, wr_cnt, wr_cpa, wr_cpb, wr_flg, wr_msk;
   logic [7:0] rd_byte;
   logic [1:0] com_a_reg;
   logic [1:0] com_b_reg;
   logic [1:0] wgm_lo_reg;
   logic wgm_hi_reg;
   tmc_clk_sel_t cs_reg;
   tmc_wave_t wave;
   logic [7:0] cnt_reg;
   logic dir_up_reg;
   logic block_reg;
   logic [2:0] flags_reg;
   logic [2:0] flags_next;
   logic [2:0] mask_reg;
   logic [2:0] irq_reg;
   logic [9:0] pre_reg;
   logic pre_tick;
   logic sync1_reg, sync2_reg, sync3_reg;
   logic ext_lvl_reg;
   logic ext_prev_reg;
   logic tick;
   logic [7:0] top;
   logic at_top;
   logic at_bottom;
   logic fast_mode;
   logic pc_mode;
   logic ovf_set;
   logic load_buf;
   logic wrap;
   logic foc_a, foc_b;
   logic match_a, match_b;
   logic [7:0] cmp_a_act, cmp_b_act;
   logic [7:0] cmp_a_rd, cmp_b_rd;

   // Bus slave: writes zero wait, reads one wait
   assign take = hsel & htrans[1] & hready;
   assign hreadyout = hreadyout_reg;
   assign hrdata = hrdata_reg;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
      end else begin
         wr_pend_reg <= take & hwrite;
         if (take) begin
            addr_reg <= haddr[7:0];
         end
         if (take && !hwrite) begin
            rd_pend_reg <= 1'b1;
            hreadyout_reg <= 1'b0;
         end else if (rd_pend_reg) begin
            rd_pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hrdata_reg <= 32'h0000_0000;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (rd_pend_reg) begin
            hrdata_reg <= {24'h00_0000, rd_byte};
         end
      end
   end

   // Address decode; unmapped reads zero, writes dropped
   always_comb begin
      wr_cta = 1'b0;
      wr_ctb = 1'b0;
      wr_ctc = 1'b0;
      wr_cnt = 1'b0;
      wr_cpa = 1'b0;
      wr_cpb = 1'b0;
      wr_flg = 1'b0;
      wr_msk = 1'b0;
      rd_byte = 8'h00;
      if (addr_reg == `TMC_OFS_CTRL_A) begin
         wr_cta = wr_pend_reg;
         rd_byte = {com_a_reg, com_b_reg, 2'b00, wgm_lo_reg};
      end else if (addr_reg == `TMC_OFS_CTRL_B) begin
         wr_ctb = wr_pend_reg;
         rd_byte = {4'h0, wgm_hi_reg, cs_reg};
      end else if (addr_reg == `TMC_OFS_CTRL_C) begin
         wr_ctc = wr_pend_reg;
      end else if (addr_reg == `TMC_OFS_COUNT) begin
         wr_cnt = wr_pend_reg;
         rd_byte = cnt_reg;
      end else if (addr_reg == `TMC_OFS_CMP_A) begin
         wr_cpa = wr_pend_reg;
         rd_byte = cmp_a_rd;
      end else if (addr_reg == `TMC_OFS_CMP_B) begin
         wr_cpb = wr_pend_reg;
         rd_byte = cmp_b_rd;
      end else if (addr_reg == `TMC_OFS_FLAGS) begin
         wr_flg = wr_pend_reg;
         rd_byte = {5'h00, flags_reg};
      end else if (addr_reg == `TMC_OFS_MASK) begin
         wr_msk = wr_pend_reg;
         rd_byte = {5'h00, mask_reg};
      end
   end

   // Control fields; output mode takes effect at once
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         com_a_reg <= 2'b00;
         com_b_reg <= 2'b00;
         wgm_lo_reg <= 2'b00;
         wgm_hi_reg <= 1'b0;
         cs_reg <= TMC_CS_STOP;
         mask_reg <= 3'b000;
      end else begin
         if (wr_cta) begin
            com_a_reg <= hwdata[`TMC_COM_A_HI:`TMC_COM_A_LO];
            com_b_reg <= hwdata[`TMC_COM_B_HI:`TMC_COM_B_LO];
            wgm_lo_reg <= hwdata[`TMC_WGM_LO_HI:`TMC_WGM_LO_LO];
         end
         if (wr_ctb) begin
            wgm_hi_reg <= hwdata[`TMC_WGM2_BIT];
            cs_reg <= tmc_clk_sel_t'(hwdata[`TMC_CS_HI:`TMC_CS_LO]);
         end
         if (wr_msk) begin
            mask_reg <= hwdata[2:0];
         end
      end
   end

   assign wave = tmc_wave_t'({wgm_hi_reg, wgm_lo_reg});
   assign foc_a = wr_ctc & hwdata[`TMC_FOC_A_BIT];
   assign foc_b = wr_ctc & hwdata[`TMC_FOC_B_BIT];

   // Prescaler
   always_ff @(posedge ref_clk) begin
      if (srst || cs_reg == TMC_CS_STOP) begin
         pre_reg <= 10'h000;
      end else begin
         pre_reg <= pre_reg + 10'h001;
      end
   end

   always_comb begin
      case (cs_reg)
         TMC_CS_DIV1: pre_tick = 1'b1;
         TMC_CS_DIV8: pre_tick = (pre_reg & `TMC_PRE_MASK_8) == `TMC_PRE_MASK_8;
         TMC_CS_DIV64: pre_tick = (pre_reg & `TMC_PRE_MASK_64) == `TMC_PRE_MASK_64;
         TMC_CS_DIV256: pre_tick = (pre_reg & `TMC_PRE_MASK_256) == `TMC_PRE_MASK_256;
         TMC_CS_DIV1024: pre_tick = pre_reg == `TMC_PRE_MASK_1024;
         default: pre_tick = 1'b0;
      endcase
   end

   // Count pin: three stages, level accepted when stages two and three agree
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         sync3_reg <= 1'b0;
         ext_lvl_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= external_count_pin;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            ext_lvl_reg <= sync3_reg;
         end
         ext_prev_reg <= ext_lvl_reg;
      end
   end

   // Timer tick selection
   always_comb begin
      case (cs_reg)
         TMC_CS_STOP: tick = 1'b0;
         TMC_CS_EXT_FALL: tick = ext_prev_reg & ~ext_lvl_reg;
         TMC_CS_EXT_RISE: tick = ext_lvl_reg & ~ext_prev_reg;
         default: tick = pre_tick;
      endcase
   end

   // Top and bottom indications
   assign fast_mode = wave == TMC_FAST_FF || wave == TMC_FAST_OCA;
   assign pc_mode = wave == TMC_PC_FF || wave == TMC_PC_OCA;
   assign top = (wave == TMC_CTC || wave == TMC_FAST_OCA || wave == TMC_PC_OCA) ?
      cmp_a_act : `TMC_MAX;
   assign at_top = cnt_reg == top;
   assign at_bottom = cnt_reg == `TMC_BOTTOM;
   assign wrap = tick & fast_mode & at_top & ~wr_cnt;
   assign load_buf = tick & at_top & (fast_mode | (pc_mode & dir_up_reg));

   // Counter unit
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg <= `TMC_RST_BYTE;
         dir_up_reg <= 1'b1;
      end else if (wr_cnt) begin
         cnt_reg <= hwdata[7:0];
      end else if (tick) begin
         if (pc_mode) begin
            if (dir_up_reg && at_top) begin
               dir_up_reg <= 1'b0;
               cnt_reg <= cnt_reg - `TMC_ONE;
            end else if (!dir_up_reg && at_bottom) begin
               dir_up_reg <= 1'b1;
               cnt_reg <= cnt_reg + `TMC_ONE;
            end else if (dir_up_reg) begin
               cnt_reg <= cnt_reg + `TMC_ONE;
            end else begin
               cnt_reg <= cnt_reg - `TMC_ONE;
            end
         end else if ((wave == TMC_CTC || fast_mode) && at_top) begin
            dir_up_reg <= 1'b1;
            cnt_reg <= `TMC_BOTTOM;
         end else begin
            dir_up_reg <= 1'b1;
            cnt_reg <= cnt_reg + `TMC_ONE;
         end
      end
   end

   // Match blocking after a counter write
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         block_reg <= 1'b0;
      end else if (wr_cnt) begin
         block_reg <= 1'b1;
      end else if (tick) begin
         block_reg <= 1'b0;
      end
   end

   // Overflow condition per mode
   always_comb begin
      if (fast_mode) begin
         ovf_set = wrap;
      end else if (pc_mode) begin
         ovf_set = tick & at_bottom & ~dir_up_reg & ~wr_cnt;
      end else begin
         ovf_set = tick & (cnt_reg == `TMC_MAX) & ~wr_cnt;
      end
   end

   // Flags: hardware set wins over any clear
   always_comb begin
      flags_next = flags_reg;
      if (wr_flg) begin
         flags_next = flags_next & ~hwdata[2:0];
      end
      flags_next = flags_next & ~{ack_compare_b, ack_compare_a, ack_overflow};
      flags_next[`TMC_FLG_OVF] = flags_next[`TMC_FLG_OVF] | ovf_set;
      flags_next[`TMC_FLG_CMP_A] = flags_next[`TMC_FLG_CMP_A] | match_a;
      flags_next[`TMC_FLG_CMP_B] = flags_next[`TMC_FLG_CMP_B] | match_b;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         flags_reg <= 3'b000;
         irq_reg <= 3'b000;
      end else begin
         flags_reg <= flags_next;
         irq_reg <= flags_reg & mask_reg;
      end
   end

   assign irq_overflow = irq_reg[`TMC_FLG_OVF];
   assign irq_compare_a = irq_reg[`TMC_FLG_CMP_A];
   assign irq_compare_b = irq_reg[`TMC_FLG_CMP_B];

   tmc_compare_unit #(.W(8), .TOGGLE_OK(1'b1)) u_cmp_a (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick),
      .block(block_reg),
      .count_value(cnt_reg),
      .wave(wave),
      .com(com_a_reg),
      .count_up(dir_up_reg),
      .load(load_buf),
      .wrap(wrap),
      .wr(wr_cpa),
      .wdata(hwdata[7:0]),
      .force_cmp(foc_a),
      .active_value(cmp_a_act),
      .read_value(cmp_a_rd),
      .match(match_a),
      .out_state(compare_a_output)
   );

   tmc_compare_unit #(.W(8), .TOGGLE_OK(1'b0)) u_cmp_b (
      .ref_clk(ref_clk),
      .srst(srst),
      .tick(tick),
      .block(block_reg),
      .count_value(cnt_reg),
      .wave(wave),
      .com(com_b_reg),
      .count_up(dir_up_reg),
      .load(load_buf),
      .wrap(wrap),
      .wr(wr_cpb),
      .wdata(hwdata[7:0]),
      .force_cmp(foc_b),
      .active_value(cmp_b_act),
      .read_value(cmp_b_rd),
      .match(match_b),
      .out_state(compare_b_output)
   );

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_cnt_write;
      wr_cnt |=> (cnt_reg == $past(hwdata[7:0]));
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

   property p_stopped;
      (cs_reg == TMC_CS_STOP && !wr_cnt) |=> $stable(cnt_reg);
   endproperty
   a_stopped: assert property (p_stopped) else $error("stopped counter moved");

   sequence s_normal_max;
      tick && wave == TMC_NORMAL && cnt_reg == `TMC_MAX && !wr_cnt;
   endsequence
   property p_normal_wrap;
      s_normal_max |=> (cnt_reg == `TMC_BOTTOM && flags_reg[`TMC_FLG_OVF]);
   endproperty
   a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

   property p_ctc_clear;
      (tick && wave == TMC_CTC && cnt_reg == cmp_a_act && !wr_cnt) |=> (cnt_reg == `TMC_BOTTOM);
   endproperty
   a_ctc_clear: assert property (p_ctc_clear) else $error("compare clear missed");

   sequence s_fast_top;
      tick && fast_mode && at_top && !wr_cnt;
   endsequence
   property p_fast_wrap;
      s_fast_top |=> (cnt_reg == `TMC_BOTTOM && flags_reg[`TMC_FLG_OVF]);
   endproperty
   a_fast_wrap: assert property (p_fast_wrap) else $error("fast wrap wrong");

   property p_block_gate;
      wr_cnt ##1 (block_reg && tick) |-> (!match_a && !match_b);
   endproperty
   a_block_gate: assert property (p_block_gate) else $error("match not blocked");

   property p_flag_set;
      match_a |=> flags_reg[`TMC_FLG_CMP_A];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("compare flag not set");

   property p_flag_clear;
      (wr_flg && hwdata[`TMC_FLG_CMP_A] && !match_a) |=> !flags_reg[`TMC_FLG_CMP_A];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

   property p_irq_gate;
      flags_reg[`TMC_FLG_CMP_B] && mask_reg[`TMC_FLG_CMP_B] |=> irq_compare_b;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt not raised");

endmodule

// ---- shared/tmc_defs.svh ----
/*
 Register offsets, field positions, reset values and prescaler masks of the
 8-bit timer/counter core. Assumes a 32-bit AHB-Lite word map, one register
 to a word, byte data in bits 7:0.
*/
`ifndef TMC_DEFS_SVH
`define TMC_DEFS_SVH

// Byte addresses
`define TMC_OFS_CTRL_A 8'h00
`define TMC_OFS_CTRL_B 8'h04
`define TMC_OFS_CTRL_C 8'h08
`define TMC_OFS_COUNT 8'h0c
`define TMC_OFS_CMP_A 8'h10
`define TMC_OFS_CMP_B 8'h14
`define TMC_OFS_FLAGS 8'h18
`define TMC_OFS_MASK 8'h1c

// Control register a fields
`define TMC_COM_A_HI 7
`define TMC_COM_A_LO 6
`define TMC_COM_B_HI 5
`define TMC_COM_B_LO 4
`define TMC_WGM_LO_HI 1
`define TMC_WGM_LO_LO 0

// Control register b fields
`define TMC_WGM2_BIT 3
`define TMC_CS_HI 2
`define TMC_CS_LO 0

// Control register c strobes
`define TMC_FOC_A_BIT 7
`define TMC_FOC_B_BIT 6

// Flag and mask bit positions
`define TMC_FLG_OVF 0
`define TMC_FLG_CMP_A 1
`define TMC_FLG_CMP_B 2

// Values
`define TMC_RST_BYTE 8'h00
`define TMC_MAX 8'hff
`define TMC_BOTTOM 8'h00
`define TMC_ONE 8'h01

// Prescaler tap masks
`define TMC_PRE_MASK_8 10'h007
`define TMC_PRE_MASK_64 10'h03f
`define TMC_PRE_MASK_256 10'h0ff
`define TMC_PRE_MASK_1024 10'h3ff

`endif

// ---- shared/tmc_pkg.sv ----
/*
 Types of the 8-bit timer/counter core: waveform modes and clock sources.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package tmc_pkg;

   typedef enum logic [2:0] {
      TMC_NORMAL = 3'b000,
      TMC_PC_FF = 3'b001,
      TMC_CTC = 3'b010,
      TMC_FAST_FF = 3'b011,
      TMC_RSV4 = 3'b100,
      TMC_PC_OCA = 3'b101,
      TMC_RSV6 = 3'b110,
      TMC_FAST_OCA = 3'b111
   } tmc_wave_t;

   typedef enum logic [2:0] {
      TMC_CS_STOP = 3'b000,
      TMC_CS_DIV1 = 3'b001,
      TMC_CS_DIV8 = 3'b010,
      TMC_CS_DIV64 = 3'b011,
      TMC_CS_DIV256 = 3'b100,
      TMC_CS_DIV1024 = 3'b101,
      TMC_CS_EXT_FALL = 3'b110,
      TMC_CS_EXT_RISE = 3'b111
   } tmc_clk_sel_t;

endpackage

// ---- tb/tmc_timer_tb_top.sv ----
/*
 Self-checking bench of the 8-bit timer/counter core, driven over AHB-Lite.
 Assumes the core is the only slave and its hreadyout is the bus hready.
*/
`timescale 1ns/1ns
`include "tmc_defs.svh"

module tmc_timer_tb_top import tmc_pkg::*; ;
   localparam logic [7:0] CA = `TMC_OFS_CTRL_A;
   localparam logic [7:0] CB = `TMC_OFS_CTRL_B;
   localparam logic [7:0] CC = `TMC_OFS_CTRL_C;
   localparam logic [7:0] CN = `TMC_OFS_COUNT;
   localparam logic [7:0] OA = `TMC_OFS_CMP_A;
   localparam logic [7:0] OB = `TMC_OFS_CMP_B;
   localparam logic [7:0] FL = `TMC_OFS_FLAGS;
   localparam logic [7:0] MK = `TMC_OFS_MASK;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic pin = 1'b0;
   logic ack_ov = 1'b0;
   logic ack_a = 1'b0;
   logic ack_b = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic irq_ov;
   logic irq_a;
   logic irq_b;
   logic out_a;
   logic out_b;
   logic [2:0] irqs;
   int fail_count = 0;
   int samples_checked = 0;

   assign irqs = {irq_b, irq_a, irq_ov};
   always #10 ref_clk = ~ref_clk;

   tmc_timer tmc_timer_inst (
      .ref_clk(ref_clk),
      .srst(srst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .external_count_pin(pin),
      .ack_overflow(ack_ov),
      .ack_compare_a(ack_a),
      .ack_compare_b(ack_b),
      .irq_overflow(irq_ov),
      .irq_compare_a(irq_a),
      .irq_compare_b(irq_b),
      .compare_a_output(out_a),
      .compare_b_output(out_b)
   );

   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 8'h00, q);
      chk(n, e, q);
   endtask

   task automatic wait_irq(input string n, input int b, input int lim);
      for (int i = 0; i < lim; i++) begin
         @(posedge ref_clk);
         if (irqs[b] === 1'b1) break;
      end
      chk(n, 32'h1, {31'h0, irqs[b]});
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      logic [31:0] q;
      tmc_clk_sel_t sel [3];
      logic [7:0] pe [3];
      sel = '{TMC_CS_EXT_RISE, TMC_CS_EXT_FALL, TMC_CS_STOP};
      pe = '{8'h03, 8'h03, 8'h00};
      repeat (4) @(posedge ref_clk);
      srst <= 1'b0;
      rd("ctrl_a", CA, 32'h0);
      rd("count", CN, 32'h0);
      rd("flags", FL, 32'h0);
      wr(8'h20, 8'hff);
      rd("unmapped", 8'h20, 32'h0);
      chk("hresp", 32'h0, {31'h0, hresp});
      wr(CN, 8'h5a);
      repeat (20) @(posedge ref_clk);
      rd("count stopped", CN, 32'h5a);
      // Force strobes: A toggles, B with mode zero holds
      wr(CA, 8'h40);
      wr(CC, 8'hc0);
      repeat (2) @(posedge ref_clk);
      chk("out_a forced", 32'h1, {31'h0, out_a});
      chk("out_b forced", 32'h0, {31'h0, out_b});
      rd("flags after force", FL, 32'h0);
      wr(CA, 8'h43);
      wr(CC, 8'h80);
      repeat (2) @(posedge ref_clk);
      chk("out_a in pwm", 32'h1, {31'h0, out_a});
      // Normal mode overflow
      wr(CA, 8'h00);
      wr(MK, 8'h01);
      wr(CN, 8'hf0);
      wr(CB, {5'h00, TMC_CS_DIV1});
      chk("irq_ov early", 32'h0, {31'h0, irq_ov});
      wait_irq("irq_ov", 0, 40);
      wr(CB, 8'h00);
      // Both compare values are zero, so both match after the wrap
      rd("flags ovf", FL, 32'h7);
      wr(FL, 8'h07);
      rd("flags cleared", FL, 32'h0);
      chk("irq_ov cleared", 32'h0, {31'h0, irq_ov});
      // Compare A with blocked first match
      wr(CA, 8'h40);
      wr(MK, 8'h02);
      wr(OA, 8'h10);
      wr(CN, 8'h10);
      wr(CB, {5'h00, TMC_CS_DIV1});
      repeat (8) @(posedge ref_clk);
      wr(CB, 8'h00);
      rd("flags blocked", FL, 32'h0);
      wr(CB, {5'h00, TMC_CS_DIV1});
      wait_irq("irq_a", 1, 300);
      wr(CB, 8'h00);
      chk("out_a toggled", 32'h0, {31'h0, out_a});
      @(posedge ref_clk);
      ack_a <= 1'b1;
      @(posedge ref_clk);
      ack_a <= 1'b0;
      rd("flags acked", FL, 32'h5);
      chk("irq_ov masked", 32'h0, {31'h0, irq_ov});
      // Buffered compare in fast pwm, direct in normal
      wr(MK, 8'h00);
      wr(CA, 8'h00);
      wr(OA, 8'hc0);
      wr(OB, 8'h80);
      for (int i = 0; i < 2; i++) begin
         wr(FL, 8'h07);
         wr(CA, i == 0 ? 8'h03 : 8'h00);
         wr(OB, 8'h05);
         rd("cmp_b read", OB, 32'h5);
         wr(CN, 8'h03);
         wr(CB, {5'h00, TMC_CS_DIV1});
         repeat (10) @(posedge ref_clk);
         wr(CB, 8'h00);
         rd("flags cmp_b", FL, i == 0 ? 32'h0 : 32'h4);
         chk("irq_b masked", 32'h0, {31'h0, irq_b});
      end
      // Clear on compare
      wr(CA, 8'h02);
      wr(OA, 8'h04);
      wr(CN, 8'h00);
      wr(FL, 8'h07);
      wr(CB, {5'h00, TMC_CS_DIV1});
      for (int i = 0; i < 6; i++) begin
         xfer(1'b0, CN, 8'h00, q);
         chk("ctc count in range", 32'h1, {31'h0, q <= 32'h4});
      end
      wr(CB, 8'h00);
      rd("flags ctc", FL, 32'h2);
      // Count pin edges per select
      wr(CA, 8'h00);
      for (int s = 0; s < 3; s++) begin
         wr(CB, {5'h00, sel[s]});
         wr(CN, 8'h00);
         repeat (3) begin
            repeat (10) @(posedge ref_clk);
            pin <= 1'b1;
            repeat (10) @(posedge ref_clk);
            pin <= 1'b0;
         end
         repeat (10) @(posedge ref_clk);
         rd("pin count", CN, {24'h0, pe[s]});
      end
      // Divide by eight: ticks at 8..72 cycles after select
      wr(CN, 8'h00);
      wr(CB, {5'h00, TMC_CS_DIV8});
      repeat (75) @(posedge ref_clk);
      wr(CB, 8'h00);
      rd("div8 count", CN, 32'h9);
      // Phase correct, top from compare a
      wr(CN, 8'h02);
      wr(CA, 8'h01);
      wr(FL, 8'h07);
      wr(CB, 8'h09);
      repeat (20) @(posedge ref_clk);
      wr(CB, 8'h00);
      rd("flags phase correct", FL, 32'h3);
      end_of_test();
   end
endmodule
